//--- verilog/spc_pin_config.sv
// Operation
// - Bits 30:28 pick LED output (1) or general pin (0) per pin.
// - Bits 26:24 pick high (1) or low (0) level to flag each pin not in LED mode.
// - A pin interrupt reaches the output only when its enable is set.
// - A level must last over 40 ns before it counts as interrupt.
// - Bits 22:20 choose what the two EEPROM pins carry.
// - Bits 18:16 pick push-pull (1) or open-drain (0) drive.
// - Bits 10:8 make a pin an output (1) or an input (0).
// - Bits 4:3 drive output-only pins a and b.
// - Bits 2:0 drive output pins; reads return live pin levels.
`timescale 1ns/100ps
module spc_pin_config
  import spc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] gpio_i,
  output logic [2:0] gpio_o,
  output logic [2:0] gpio_oe,
  input wire logic [2:0] led_state,
  input wire logic ee_ctl_do,
  input wire logic ee_ctl_oe,
  input wire logic ee_ctl_clk,
  output logic ee_ctl_di,
  input wire logic eeprom_data_pin_i,
  output logic eeprom_data_pin_o,
  output logic eeprom_data_pin_oe,
  output logic eeprom_clock_pin_o,
  output logic eeprom_clock_pin_oe,
  input wire logic tx_en_mon,
  input wire logic tx_clk_mon,
  input wire logic rx_valid_monitor,
  input wire logic rx_clk_mon,
  output logic irq
);

  spc_cfg_t cfg_q, cfg_d;
  logic [2:0] sts_q, sts_d;
  logic [2:0] ena_q, ena_d;
  logic [3:0] sync1_q, sync2_q;
  logic [2:0] pin_s;
  logic [2:0] filt;
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_wr;
  logic [31:0] bm;

  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction

  // Two-stage synchronisers for pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {eeprom_data_pin_i, gpio_i};
      sync2_q <= sync1_q;
    end
  end

  assign pin_s = sync2_q[2:0];
  assign ee_ctl_di = sync2_q[3];

  // AXI4-Lite handshakes
  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign bm = byte_mask(ws_q);

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    wa_d = wa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      wa_d = awaddr;
    end
    if (wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      if (wa_q == PFC_OFS || wa_q == STS_OFS || wa_q == ENA_OFS) begin
        bresp_d = RESP_OKAY;
      end else begin
        bresp_d = RESP_DECERR;
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      if (araddr == PFC_OFS) begin
        // Data bits return the live pin levels
        rdata_d = {cfg_q[31:3] & CFG_WMASK[31:3], pin_s};
      end else if (araddr == STS_OFS) begin
        rdata_d = {29'h0, sts_q};
      end else if (araddr == ENA_OFS) begin
        rdata_d = {29'h0, ena_q};
      end else begin
        rdata_d = 32'h0;
        rresp_d = RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wa_q <= 8'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Register file; hardware set wins over write-one-clear
  always_comb begin
    cfg_d = cfg_q;
    ena_d = ena_q;
    sts_d = sts_q;
    if (do_wr && wa_q == PFC_OFS) begin
      cfg_d = (cfg_q & ~bm) | (wd_q & bm & CFG_WMASK);
    end
    if (do_wr && wa_q == ENA_OFS) begin
      ena_d = (ena_q & ~bm[2:0]) | (wd_q[2:0] & bm[2:0]);
    end
    if (do_wr && wa_q == STS_OFS) begin
      sts_d = sts_q & ~(wd_q[2:0] & bm[2:0]);
    end
    sts_d = sts_d | filt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RST;
      sts_q <= IRQ_RST;
      ena_q <= IRQ_RST;
    end else begin
      cfg_q <= cfg_d;
      sts_q <= sts_d;
      ena_q <= ena_d;
    end
  end

  assign irq = |(sts_q & ena_q);
  // Per pin: level filter and output driver
  for (genvar i = 0; i < 3; i++) begin : g_pin
    logic [2:0] cnt_q, cnt_d;
    logic act;
    spc_pin_t drv;

    always_comb begin
      act = (pin_s[i] == cfg_q.pin_irq_level_sel[i])
        && !cfg_q.led_select[i];
      cnt_d = cnt_q;
      if (!act) begin
        cnt_d = 3'h0;
      end else if (cnt_q != FILT_CNT) begin
        cnt_d = cnt_q + 3'h1;
      end
      if (cfg_q.led_select[i]) begin
        drv = '{o: led_state[i], oe: 1'b1};
      end else if (!cfg_q.pin_direction[i]) begin
        drv = '{o: 1'b0, oe: 1'b0};
      end else if (cfg_q.pin_drive_type[i]) begin
        drv = '{o: cfg_q.pin_value[i], oe: 1'b1};
      end else begin
        drv = '{o: 1'b0, oe: !cfg_q.pin_value[i]};
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= cnt_d;
      end
    end

    assign filt[i] = (cnt_q == FILT_CNT);
    assign gpio_o[i] = drv.o;
    assign gpio_oe[i] = drv.oe;
  end

  // EEPROM pin function mux
  always_comb begin
    eeprom_data_pin_o = 1'b0;
    eeprom_data_pin_oe = 1'b1;
    eeprom_clock_pin_o = 1'b0;
    eeprom_clock_pin_oe = 1'b1;
    case (cfg_q.eeprom_pin_function)
      EE_NATIVE: begin
        eeprom_data_pin_o = ee_ctl_do;
        eeprom_data_pin_oe = ee_ctl_oe;
        eeprom_clock_pin_o = ee_ctl_clk;
      end
      EE_GPO: begin
        eeprom_data_pin_o = cfg_q.out_only_value[0];
        eeprom_clock_pin_o = cfg_q.out_only_value[1];
      end
      EE_GPO_RXDV: begin
        eeprom_data_pin_o = cfg_q.out_only_value[0];
        eeprom_clock_pin_o = rx_valid_monitor;
      end
      EE_TXEN_GPO: begin
        eeprom_data_pin_o = tx_en_mon;
        eeprom_clock_pin_o = cfg_q.out_only_value[1];
      end
      EE_TXEN_RXDV: begin
        eeprom_data_pin_o = tx_en_mon;
        eeprom_clock_pin_o = rx_valid_monitor;
      end
      EE_CLKS: begin
        eeprom_data_pin_o = tx_clk_mon;
        eeprom_clock_pin_o = rx_clk_mon;
      end
      // Reserved codes leave both pins undriven
      default: begin
        eeprom_data_pin_oe = 1'b0;
        eeprom_clock_pin_oe = 1'b0;
      end
    endcase
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LED_DRIVE: assert property (
    cfg_q.led_select[0] |-> gpio_oe[0] && gpio_o[0] == led_state[0])
    else $error("LED pin not driven from LED state");
  AST_POLARITY: assert property (
    $rose(sts_q[1]) |->
      $past(pin_s[1], 2) == $past(cfg_q.pin_irq_level_sel[1], 2))
    else $error("Status set at wrong level");
  AST_IRQ_GATE: assert property (
    $rose(irq) |-> $changed(ena_q) || $past(filt) != 3'h0)
    else $error("Interrupt rose without event or enable write");
  AST_FILTER: assert property (
    $rose(sts_q[0]) |-> $past(filt[0]) &&
      $past(g_pin[0].cnt_q, 2) >= FILT_CNT - 3'h1)
    else $error("Short pulse recognised");
  AST_GPO_MODE: assert property (
    cfg_q.eeprom_pin_function == EE_GPO |-> eeprom_data_pin_o ==
      cfg_q.out_only_value[0] && eeprom_clock_pin_o == cfg_q.out_only_value[1])
    else $error("Output-only pins wrong");
  AST_CLK_MODE: assert property (
    cfg_q.eeprom_pin_function == EE_CLKS |-> eeprom_clock_pin_o ==
      rx_clk_mon && eeprom_data_pin_o == tx_clk_mon && eeprom_data_pin_oe)
    else $error("Clock monitor mapping wrong");
  AST_OPEN_DRAIN: assert property (
    !cfg_q.led_select[2] && cfg_q.pin_direction[2] && !cfg_q.pin_drive_type[2]
      |-> !gpio_o[2] && gpio_oe[2] == !cfg_q.pin_value[2])
    else $error("Open-drain drive wrong");
  AST_INPUT: assert property (
    !cfg_q.led_select[1] && !cfg_q.pin_direction[1] |-> !gpio_oe[1])
    else $error("Input pin driven");
  AST_READBACK: assert property (
    arvalid && arready && araddr == PFC_OFS |=> rdata[2:0] == $past(pin_s))
    else $error("Read-back not live pin state");
  AST_RESET: assert property (disable iff (1'b0)
    !aresetn |=> cfg_q == CFG_RST && sts_q == IRQ_RST && !irq)
    else $error("Reset values wrong");

endmodule

//--- verilog/spc_pkg.sv
package spc_pkg;

  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] STS_OFS = 8'h80;
  localparam logic [ADDR_W-1:0] ENA_OFS = 8'h84;
  localparam logic [ADDR_W-1:0] PFC_OFS = 8'h88;

  localparam logic [31:0] CFG_WMASK = 32'h7777071f;
  localparam logic [31:0] CFG_RST = 32'h00000000;
  localparam logic [2:0] IRQ_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_NS = 40;
  // Level must stay strictly longer than the filter time
  localparam int FILT_CYC = FILT_NS / CLK_PERIOD_NS + 1;
  localparam logic [2:0] FILT_CNT = 3'(FILT_CYC);

  typedef enum logic [2:0] {
    EE_NATIVE = 3'h0,
    EE_GPO = 3'h1,
    EE_RSV2 = 3'h2,
    EE_GPO_RXDV = 3'h3,
    EE_RSV4 = 3'h4,
    EE_TXEN_GPO = 3'h5,
    EE_TXEN_RXDV = 3'h6,
    EE_CLKS = 3'h7
  } spc_ee_mode_t;

  typedef struct packed {
    logic rsv31;
    logic [2:0] led_select;
    logic rsv27;
    logic [2:0] pin_irq_level_sel;
    logic rsv23;
    spc_ee_mode_t eeprom_pin_function;
    logic rsv19;
    logic [2:0] pin_drive_type;
    logic [4:0] rsv15;
    logic [2:0] pin_direction;
    logic [2:0] rsv7;
    logic [1:0] out_only_value;
    logic [2:0] pin_value;
  } spc_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } spc_pin_t;

endpackage

//--- verification/spc_board.sv
`timescale 1ns/100ps
module spc_board (
  input wire logic [2:0] gpio_o,
  input wire logic [2:0] gpio_oe,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  input wire logic ee_o,
  input wire logic ee_oe,
  output logic [2:0] pin,
  output logic ee_pin
);
  // Board pull-ups lift every line that neither the DUT nor ext_en drives
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin[i] = gpio_oe[i] ? gpio_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
    ee_pin = ee_oe ? ee_o : 1'b1;
  end
endmodule

//--- verification/spc_pin_config_tb.sv
`timescale 1ns/100ps
module spc_pin_config_tb
  import spc_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, c, lv;
  logic [3:0] ex;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] gpio_o, gpio_oe, led_state, pin, ext_en, ext_val, eo, eoe;
  logic ee_ctl_do, ee_ctl_oe, ee_ctl_clk, ee_ctl_di, ee_pin, ee_o, ee_oe;
  logic ck_o, ck_oe, tx_en_mon, tx_clk_mon, rx_valid_monitor, rx_clk_mon;
  int errors, cmp_count, cyc;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};

  spc_pin_config i_spc_pin_config (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .gpio_i(pin), .gpio_o, .gpio_oe, .led_state,
    .ee_ctl_do, .ee_ctl_oe, .ee_ctl_clk, .ee_ctl_di,
    .eeprom_data_pin_i(ee_pin), .eeprom_data_pin_o(ee_o),
    .eeprom_data_pin_oe(ee_oe), .eeprom_clock_pin_o(ck_o),
    .eeprom_clock_pin_oe(ck_oe), .tx_en_mon, .tx_clk_mon,
    .rx_valid_monitor, .rx_clk_mon, .irq
  );

  spc_board i_spc_board (
    .gpio_o, .gpio_oe, .ext_en, .ext_val, .ee_o, .ee_oe, .pin, .ee_pin
  );

  // Expected {oe, o} of one shared pin
  function automatic logic [1:0] drv(logic [31:0] v, int i, logic led);
    if (v[28+i]) return {1'b1, led};
    if (!v[8+i]) return 2'b00;
    if (v[16+i]) return {1'b1, v[i]};
    return {!v[i], 1'b0};
  endfunction

  // Expected {data oe, data, clock oe, clock} of the EEPROM pins
  function automatic logic [3:0] eexp(logic [31:0] v);
    case (v[22:20])
      3'h0: return {ee_ctl_oe, ee_ctl_do, 1'b1, ee_ctl_clk};
      3'h1: return {1'b1, v[3], 1'b1, v[4]};
      3'h3: return {1'b1, v[3], 1'b1, rx_valid_monitor};
      3'h5: return {1'b1, tx_en_mon, 1'b1, v[4]};
      3'h6: return {1'b1, tx_en_mon, 1'b1, rx_valid_monitor};
      default: return {1'b1, tx_clk_mon, 1'b1, rx_clk_mon};
    endcase
  endfunction

  task automatic chk(logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task automatic test_done();
    $display("errors %0d, compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Cuts a hung handshake short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, led_state, ext_en, ext_val} = '0;
    {ee_ctl_do, ee_ctl_oe, ee_ctl_clk, tx_en_mon, tx_clk_mon} = '0;
    {rx_valid_monitor, rx_clk_mon} = '0;
    wstrb = 4'hf;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(9));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'({gpio_oe, ck_oe}), 32'h1);
    rd(PFC_OFS, 32'h7, RESP_OKAY);
    rd(STS_OFS, 32'h0, RESP_OKAY);
    rd(8'h8c, 32'h0, RESP_DECERR);
    wr(8'h8c, 32'hffffffff, RESP_DECERR);
    wstrb <= 4'h2;
    wr(PFC_OFS, 32'hffffffff, RESP_OKAY);
    wstrb <= 4'hf;
    repeat (2) @(posedge aclk);
    rd(PFC_OFS, 32'h700, RESP_OKAY);
    for (int k = 0; k < 10; k++) begin
      c = (k == 0) ? 32'hffffffff : $urandom;
      if (c[22:20] == 3'h2 || c[22:20] == 3'h4) c[22:20] = 3'h0;
      led_state <= 3'($urandom);
      wr(PFC_OFS, c, RESP_OKAY);
      repeat (3) @(posedge aclk);
      lv = c & CFG_WMASK & 32'hfffffff8;
      for (int i = 0; i < 3; i++) begin
        {eoe[i], eo[i]} = drv(c, i, led_state[i]);
        lv[i] = eoe[i] ? eo[i] : 1'b1;
      end
      chk(32'({gpio_oe, gpio_o}), 32'({eoe, eo}));
      rd(PFC_OFS, lv, RESP_OKAY);
    end
    foreach (modes[m]) begin
      {ee_ctl_do, ee_ctl_oe, ee_ctl_clk} <= 3'h0;
      c = $urandom & 32'h18;
      c[22:20] = modes[m];
      wr(PFC_OFS, c, RESP_OKAY);
      {ee_ctl_do, ee_ctl_oe, ee_ctl_clk, tx_en_mon} <= 4'($urandom);
      {tx_clk_mon, rx_valid_monitor, rx_clk_mon} <= 3'($urandom);
      @(posedge aclk);
      ex = eexp(c);
      chk(32'({ee_oe, ee_o, ck_oe, ck_o}), 32'(ex));
      repeat (2) @(posedge aclk);
      chk(32'(ee_ctl_di), 32'(ex[3] ? ex[2] : 1'b1));
    end
    {ee_ctl_do, ee_ctl_oe, ee_ctl_clk} <= 3'h0;
    {ext_en, ext_val} <= {3'b011, 3'b010};
    wr(PFC_OFS, 32'h01000000, RESP_OKAY);
    repeat (4) @(posedge aclk);
    wr(STS_OFS, 32'h7, RESP_OKAY);
    wr(ENA_OFS, 32'h1, RESP_OKAY);
    rd(STS_OFS, 32'h0, RESP_OKAY);
    for (int n = 4; n < 6; n++) begin
      ext_val[0] <= 1'b1;
      repeat (n) @(posedge aclk);
      ext_val[0] <= 1'b0;
      repeat (10) @(posedge aclk);
      chk(32'(irq), 32'(n == 5));
      rd(STS_OFS, 32'(n == 5), RESP_OKAY);
    end
    wr(STS_OFS, 32'h1, RESP_OKAY);
    wr(ENA_OFS, 32'h0, RESP_OKAY);
    ext_val[1] <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(STS_OFS, 32'h2, RESP_OKAY);
    rd(STS_OFS, 32'h2, RESP_OKAY);
    ext_val[1] <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'(irq), 32'h0);
    rd(STS_OFS, 32'h2, RESP_OKAY);
    wr(ENA_OFS, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(STS_OFS, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    rd(STS_OFS, 32'h0, RESP_OKAY);
    test_done();
  end
endmodule
